// [logic/tmw_pkg.sv]
// Package with register map, field layout, mode codes and state types.
package tmw_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CNT_OFS = 8'h00;
    localparam logic [7:0] CMPA_OFS = 8'h04;
    localparam logic [7:0] CMPB_OFS = 8'h08;
    localparam logic [7:0] CAP_OFS = 8'h0C;
    localparam logic [7:0] CTRL_OFS = 8'h10;
    localparam logic [7:0] FLAG_OFS = 8'h14;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int ACTA_LSB = 4;
    localparam int ACTB_LSB = 6;
    localparam int DIRA_BIT = 8;
    localparam int DIRB_BIT = 9;

    // ------------------------------------------------------------------
    // Flag register bits
    // ------------------------------------------------------------------
    localparam int OVF_BIT = 0;
    localparam int CMPA_BIT = 1;
    localparam int CMPB_BIT = 2;
    localparam int CAP_BIT = 3;

    // ------------------------------------------------------------------
    // Waveform mode codes
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
    localparam logic [3:0] MODE_FAST8 = 4'h5;
    localparam logic [3:0] MODE_FAST9 = 4'h6;
    localparam logic [3:0] MODE_FAST10 = 4'h7;
    localparam logic [3:0] MODE_CTC_CAP = 4'hC;
    localparam logic [3:0] MODE_FAST_CAP = 4'hE;
    localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

    // ------------------------------------------------------------------
    // Counter limits and output actions
    // ------------------------------------------------------------------
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // ------------------------------------------------------------------
    // Reset values and state types
    // ------------------------------------------------------------------
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [31:0] RD_IDLE = 32'h0000_0000;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cmpA;
        logic [15:0] cmpABuf;
        logic [15:0] cmpB;
        logic [15:0] capture;
        logic [3:0] mode;
        logic [1:0] actA;
        logic [1:0] actB;
        logic dirA;
        logic dirB;
        logic [3:0] flags;
        logic blk;
        logic [31:0] rdData;
    } tmw_state_t;

    typedef struct packed {
        logic wave;
    } tmw_cmp_state_t;

endpackage

// [logic/tmw_compare.sv]
// One compare output channel: the internal waveform output bit.
`timescale 1ns/1ps
`default_nettype none

module tmw_compare #(
    parameter bit TOGGLE_IN_PWM = 1'b1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic tickEn,
    input wire logic fastMode,
    input wire logic matchHit,
    input wire logic bottomHit,
    input wire logic [1:0] actSel,
    output logic waveBit
);

    tmw_pkg::tmw_cmp_state_t st;
    tmw_pkg::tmw_cmp_state_t next_st;

    // Output action per timer tick; the BOTTOM action wins over a match.
    always_comb begin
        next_st = st;
        if (tickEn) begin
            if (!fastMode) begin
                if (matchHit) begin
                    case (actSel)
                        tmw_pkg::ACT_TOGGLE: next_st.wave = ~st.wave;
                        tmw_pkg::ACT_CLEAR: next_st.wave = 1'b0;
                        tmw_pkg::ACT_SET: next_st.wave = 1'b1;
                        default: next_st.wave = st.wave;
                    endcase
                end
            end else begin
                case (actSel)
                    tmw_pkg::ACT_TOGGLE: begin
                        if (TOGGLE_IN_PWM && matchHit) begin
                            next_st.wave = ~st.wave;
                        end
                    end
                    tmw_pkg::ACT_CLEAR: begin
                        if (bottomHit) begin
                            next_st.wave = 1'b1;
                        end else if (matchHit) begin
                            next_st.wave = 1'b0;
                        end
                    end
                    tmw_pkg::ACT_SET: begin
                        if (bottomHit) begin
                            next_st.wave = 1'b0;
                        end else if (matchHit) begin
                            next_st.wave = 1'b1;
                        end
                    end
                    default: next_st.wave = st.wave;
                endcase
            end
        end
    end

    // State register, cleared by system reset.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign waveBit = st.wave;

    chk_wave_reset: assert property (@(posedge sys_clk)
        sys_rst |=> !waveBit)
        else $error("wave bit not cleared by reset");

    chk_no_action: assert property (@(posedge sys_clk)
        disable iff (sys_rst) actSel == tmw_pkg::ACT_NONE |=> $stable(waveBit))
        else $error("wave bit moved with no action selected");

    chk_pwm_bottom: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && fastMode && bottomHit && actSel == tmw_pkg::ACT_CLEAR
        |=> waveBit)
        else $error("non-inverted output not set at bottom");

    chk_ctc_toggle: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && !fastMode && matchHit && actSel == tmw_pkg::ACT_TOGGLE
        |=> waveBit != $past(waveBit))
        else $error("output did not toggle on match");

endmodule
`default_nettype wire

// [logic/tmw_timer.sv]
// Sixteen-bit timer with normal, clear-on-match and fast PWM modes.
//
// Notes on behaviour
// - Mode zero counts up and wraps freely.
// - Normal mode sets overflow when count hits zero.
// - Clear-on-match clears after compare A or capture.
// - Clear-on-match TOP register is written directly.
// - Clear-on-match sets the TOP register's flag.
// - Toggle action inverts output A on match.
// - Pin shows the wave only when directed out.
// - Clear-on-match sets overflow on MAX rollover.
// - Modes 5,6,7,14,15 run single-slope PWM.
// - PWM TOP is fixed, capture or compare A.
// - Non-inverting clears on match, sets at BOTTOM.
// - Action two non-inverted, three inverted PWM.
// - PWM sets overflow and TOP flag at TOP.
// - PWM sets compare flags on every match.
// - Fixed TOP masks high compare bits on write.
// - Capture as PWM TOP is written directly.
// - PWM compare A buffered, loaded at TOP.
// - Zero compare spikes, TOP compare holds constant.
// - PWM toggle on output A stays buffered.
// - Output actions never change the counting sequence.
// - Reset clears each internal waveform bit.
// - Count write blocks matches next timer tick.
// - Action zero leaves the waveform bit alone.
`timescale 1ns/1ps
`default_nettype none

module tmw_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic tickEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    output logic waveOutA,
    output logic waveOutAOe_n,
    output logic waveOutB,
    output logic waveOutBOe_n
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
        $error("ADDR_W must lie between 5 and 8");
    end

    tmw_pkg::tmw_state_t st;
    tmw_pkg::tmw_state_t next_st;

    logic [7:0] addr;
    logic isFast;
    logic isCtc;
    logic [15:0] top;
    logic [15:0] wrMask;
    logic topHit;
    logic [1:0] matchVec;
    logic [1:0] actVec [2];
    logic [1:0] waveVec;
    logic [3:0] flagSet;
    logic [3:0] flagClr;
    logic [15:0] wrVal;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------

    // Bus address is widened to the package offset width.
    assign addr = 8'(regAddr);
    assign wrVal = regWrData[15:0];

    // Only the mode field picks the counting sequence.
    assign isFast = st.mode == tmw_pkg::MODE_FAST8 ||
                    st.mode == tmw_pkg::MODE_FAST9 ||
                    st.mode == tmw_pkg::MODE_FAST10 ||
                    st.mode == tmw_pkg::MODE_FAST_CAP ||
                    st.mode == tmw_pkg::MODE_FAST_CMPA;
    assign isCtc = st.mode == tmw_pkg::MODE_CTC_CMPA ||
                   st.mode == tmw_pkg::MODE_CTC_CAP;

    // TOP and the write mask follow the selected mode.
    always_comb begin
        wrMask = tmw_pkg::TOP_MAX;
        case (st.mode)
            tmw_pkg::MODE_CTC_CMPA: top = st.cmpA;
            tmw_pkg::MODE_CTC_CAP: top = st.capture;
            tmw_pkg::MODE_FAST8: begin
                top = tmw_pkg::TOP_8BIT;
                wrMask = tmw_pkg::TOP_8BIT;
            end
            tmw_pkg::MODE_FAST9: begin
                top = tmw_pkg::TOP_9BIT;
                wrMask = tmw_pkg::TOP_9BIT;
            end
            tmw_pkg::MODE_FAST10: begin
                top = tmw_pkg::TOP_10BIT;
                wrMask = tmw_pkg::TOP_10BIT;
            end
            tmw_pkg::MODE_FAST_CAP: top = st.capture;
            tmw_pkg::MODE_FAST_CMPA: top = st.cmpA;
            default: top = tmw_pkg::TOP_MAX;
        endcase
    end

    // A blocked tick sees neither TOP nor any compare match.
    assign topHit = !st.blk && st.count == top;
    assign matchVec[0] = !st.blk && st.count == st.cmpA;
    assign matchVec[1] = !st.blk && st.count == st.cmpB;
    assign actVec[0] = st.actA;
    assign actVec[1] = st.actB;

    // Flag events of this timer tick.
    always_comb begin
        flagSet = '0;
        if (tickEn) begin
            if (isFast) begin
                flagSet[tmw_pkg::OVF_BIT] = topHit;
            end else begin
                flagSet[tmw_pkg::OVF_BIT] =
                    st.count == tmw_pkg::TOP_MAX;
            end
            flagSet[tmw_pkg::CMPA_BIT] = matchVec[0];
            flagSet[tmw_pkg::CMPB_BIT] = matchVec[1];
            flagSet[tmw_pkg::CAP_BIT] = topHit &&
                (st.mode == tmw_pkg::MODE_CTC_CAP ||
                 st.mode == tmw_pkg::MODE_FAST_CAP);
        end
    end

    // Write-one-to-clear mask for the flag register.
    always_comb begin
        flagClr = '0;
        if (regWrStb && addr == tmw_pkg::FLAG_OFS) begin
            flagClr = regWrData[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // Counter step first, then software writes, which override it.
    always_comb begin
        next_st = st;
        next_st.rdData = tmw_pkg::RD_IDLE;
        if (tickEn) begin
            next_st.blk = 1'b0;
            if ((isFast || isCtc) && topHit) begin
                next_st.count = tmw_pkg::BOTTOM;
            end else begin
                next_st.count = st.count + tmw_pkg::COUNT_STEP;
            end
            if (isFast && topHit) begin
                next_st.cmpA = st.cmpABuf;
            end
        end
        // A hardware set in the same cycle beats the software clear.
        next_st.flags = (st.flags & ~flagClr) | flagSet;
        if (regWrStb) begin
            if (addr == tmw_pkg::CNT_OFS) begin
                next_st.count = wrVal;
                next_st.blk = 1'b1;
            end else if (addr == tmw_pkg::CMPA_OFS) begin
                next_st.cmpABuf = wrVal & wrMask;
                if (!isFast) begin
                    next_st.cmpA = wrVal & wrMask;
                end
            end else if (addr == tmw_pkg::CMPB_OFS) begin
                next_st.cmpB = wrVal & wrMask;
            end else if (addr == tmw_pkg::CAP_OFS) begin
                next_st.capture = wrVal;
            end else if (addr == tmw_pkg::CTRL_OFS) begin
                next_st.mode = regWrData[tmw_pkg::MODE_LSB +: 4];
                next_st.actA = regWrData[tmw_pkg::ACTA_LSB +: 2];
                next_st.actB = regWrData[tmw_pkg::ACTB_LSB +: 2];
                next_st.dirA = regWrData[tmw_pkg::DIRA_BIT];
                next_st.dirB = regWrData[tmw_pkg::DIRB_BIT];
            end
        end
        if (regRdStb) begin
            if (addr == tmw_pkg::CNT_OFS) begin
                next_st.rdData = {16'h0000, st.count};
            end else if (addr == tmw_pkg::CMPA_OFS) begin
                next_st.rdData = {16'h0000, st.cmpABuf};
            end else if (addr == tmw_pkg::CMPB_OFS) begin
                next_st.rdData = {16'h0000, st.cmpB};
            end else if (addr == tmw_pkg::CAP_OFS) begin
                next_st.rdData = {16'h0000, st.capture};
            end else if (addr == tmw_pkg::CTRL_OFS) begin
                next_st.rdData = {22'h0, st.dirB, st.dirA,
                                  st.actB, st.actA, st.mode};
            end else if (addr == tmw_pkg::FLAG_OFS) begin
                next_st.rdData = {28'h0, st.flags};
            end
        end
    end

    // State register; reset starts in normal counting, outputs off.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Compare output channels
    // ------------------------------------------------------------------

    // Channel A may toggle in PWM; channel B holds on that setting.
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        tmw_compare #(
            .TOGGLE_IN_PWM(ch == 0)
        ) u_cmp (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .tickEn(tickEn),
            .fastMode(isFast),
            .matchHit(matchVec[ch]),
            .bottomHit(topHit),
            .actSel(actVec[ch]),
            .waveBit(waveVec[ch])
        );
    end

    // Pin drivers: enable is low while the direction bit says output.
    assign waveOutA = waveVec[0];
    assign waveOutAOe_n = !st.dirA;
    assign waveOutB = waveVec[1];
    assign waveOutBOe_n = !st.dirB;
    assign regRdData = st.rdData;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    chk_normal_wrap: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && !regWrStb && st.mode == tmw_pkg::MODE_NORMAL &&
        st.count == tmw_pkg::TOP_MAX |=> st.count == tmw_pkg::BOTTOM)
        else $error("normal mode did not wrap to zero");

    chk_normal_ovf: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && !isFast && st.count == tmw_pkg::TOP_MAX
        |=> st.flags[tmw_pkg::OVF_BIT])
        else $error("overflow flag missed at rollover");

    chk_ctc_clear: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && !regWrStb && isCtc && topHit
        |=> st.count == tmw_pkg::BOTTOM &&
            ($past(st.mode) == tmw_pkg::MODE_CTC_CMPA ?
             st.flags[tmw_pkg::CMPA_BIT] : st.flags[tmw_pkg::CAP_BIT]))
        else $error("clear-on-match did not clear or flag");

    chk_fast_top: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && !regWrStb && isFast && topHit
        |=> st.flags[tmw_pkg::OVF_BIT] && st.count == tmw_pkg::BOTTOM)
        else $error("PWM TOP did not set overflow");

    chk_buffer_load: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && isFast && topHit |=> st.cmpA == $past(st.cmpABuf))
        else $error("compare A not loaded from buffer at TOP");

    chk_buffer_hold: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        isFast && !(tickEn && topHit) |=> $stable(st.cmpA))
        else $error("buffered compare A changed away from TOP");

    chk_fixed_mask: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        regWrStb && addr == tmw_pkg::CMPB_OFS &&
        st.mode == tmw_pkg::MODE_FAST8 |=> st.cmpB[15:8] == 8'h00)
        else $error("high compare bits not masked");

    chk_match_block: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && st.blk && !regWrStb
        |=> $stable(st.flags[tmw_pkg::CMPA_BIT]) &&
            $stable(st.flags[tmw_pkg::CMPB_BIT]))
        else $error("match not blocked after count write");

    chk_no_tick: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        !tickEn && !regWrStb |=> $stable(st.count) && $stable(st.cmpA))
        else $error("counter moved without a tick");

    chk_pin_dir: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        waveOutAOe_n == !st.dirA && waveOutBOe_n == !st.dirB)
        else $error("pin enable does not follow direction");

    chk_reset_zero: assert property (@(posedge sys_clk)
        sys_rst |=> st.count == tmw_pkg::VAL_RST &&
        st.flags == tmw_pkg::FLAGS_RST && st.mode == tmw_pkg::MODE_NORMAL)
        else $error("reset did not clear timer state");

    // Direct writes, fixed TOP and flag events as software sees them.

    chk_fixed_top: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && !regWrStb && !st.blk && st.mode == tmw_pkg::MODE_FAST8 &&
        st.count == tmw_pkg::TOP_8BIT |=> st.count == tmw_pkg::BOTTOM)
        else $error("fixed eight-bit TOP did not clear the counter");

    chk_cap_flag: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && topHit && (st.mode == tmw_pkg::MODE_CTC_CAP ||
        st.mode == tmw_pkg::MODE_FAST_CAP) |=> st.flags[tmw_pkg::CAP_BIT])
        else $error("capture flag missed at TOP");

    chk_cmpb_flag: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        tickEn && !st.blk && st.count == st.cmpB
        |=> st.flags[tmw_pkg::CMPB_BIT])
        else $error("compare B flag missed at match");

    chk_direct_cap: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        regWrStb && addr == tmw_pkg::CAP_OFS |=> st.capture == $past(wrVal))
        else $error("capture register not written directly");

    chk_direct_cmpa: assert property (@(posedge sys_clk)
        disable iff (sys_rst)
        regWrStb && addr == tmw_pkg::CMPA_OFS && !isFast
        |=> st.cmpA == $past(wrVal))
        else $error("compare A not written directly outside PWM");

endmodule
`default_nettype wire

// [testbench/tmw_load_model.sv]
// External load model hanging on the channel A waveform pin.
`timescale 1ns/1ps
`default_nettype none

module tmw_load_model (
    input wire logic sys_clk,
    input wire logic waveIn,
    input wire logic waveOe_n,
    output logic pinLevel,
    output logic [7:0] riseCount
);
    // ------------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------------
    logic lastDriven = 1'b0;
    logic prevLevel = 1'b0;
    logic [7:0] rises = 8'h00;

    // Only the clocked process below writes the rise counter.
    assign riseCount = rises;

    // An undriven pin floats away from the last driven level on purpose.
    assign pinLevel = waveOe_n ? ~lastDriven : waveIn;

    // Remembers the driven level and counts rising edges seen at the pin.
    always_ff @(posedge sys_clk) begin
        if (!waveOe_n) begin
            lastDriven <= waveIn;
        end
        prevLevel <= pinLevel;
        if (pinLevel && !prevLevel) begin
            rises <= rises + 8'h01;
        end
    end
endmodule

`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the sixteen-bit timer mode logic.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct {
        logic [3:0] mode;
        logic [15:0] cap;
        logic [15:0] cmpA;
        logic [15:0] cnt;
        logic [31:0] flags;
    } tmw_row_t;

    logic sys_clk, sys_rst, tickEn, regWrStb, regRdStb;
    logic [7:0] regAddr;
    logic [31:0] regWrData, regRdData, rd;
    logic waveOutA, waveOutAOe_n, waveOutB, waveOutBOe_n, pinLevel;
    logic [7:0] riseCount, riseStart;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    tmw_row_t rows [8];

    tmw_timer u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .tickEn(tickEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .waveOutA(waveOutA),
        .waveOutAOe_n(waveOutAOe_n), .waveOutB(waveOutB),
        .waveOutBOe_n(waveOutBOe_n));

    tmw_load_model u_load (.sys_clk(sys_clk), .waveIn(waveOutA),
        .waveOe_n(waveOutAOe_n), .pinLevel(pinLevel), .riseCount(riseCount));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One write cycle; the gap cycle keeps strobes from colliding.
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask

    // Holds the tick enable high for exactly n sampling edges.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            tickEn <= 1'b1;
        end
        @(posedge sys_clk);
        tickEn <= 1'b0;
        #1;
    endtask

    function automatic logic [31:0] ctrl(input logic [3:0] m,
                                         input logic [1:0] a, input logic d);
        return {22'h0, 1'b0, d, 2'h0, a, m};
    endfunction

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Cuts a hung run short.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        sys_rst = 1'b1;
        tickEn = 1'b0;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        regAddr = 8'h00;
        regWrData = 32'h0000_0000;
        // Every top is at least three; compare A equals TOP or lies outside the two counts the row visits.
        rows = '{'{4'h0, 16'hFFFF, 16'h1000, 16'hFFFE, 32'h0000_0001},
                 '{4'h4, 16'hFFFF, 16'h0010, 16'h000F, 32'h0000_0002},
                 '{4'hC, 16'h0020, 16'h1000, 16'h001F, 32'h0000_0008},
                 '{4'h5, 16'hFFFF, 16'h1000, 16'h00FE, 32'h0000_0001},
                 '{4'h6, 16'hFFFF, 16'h1000, 16'h01FE, 32'h0000_0001},
                 '{4'h7, 16'hFFFF, 16'h1000, 16'h03FE, 32'h0000_0001},
                 '{4'hE, 16'h0040, 16'h1000, 16'h003F, 32'h0000_0009},
                 '{4'hF, 16'hFFFF, 16'h0050, 16'h004F, 32'h0000_0003}};
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        regRead(tmw_pkg::CTRL_OFS, rd);
        check("control", rd, 32'h0000_0000);
        regRead(tmw_pkg::FLAG_OFS, rd);
        check("flags", rd, 32'h0000_0000);
        check("oe", {31'h0, waveOutAOe_n}, 32'h0000_0001);
        check("wave", {31'h0, waveOutA}, 32'h0000_0000);
        check("oeB", {31'h0, waveOutBOe_n}, 32'h0000_0001);
        check("waveB", {31'h0, waveOutB}, 32'h0000_0000);
        // Each row starts one tick below TOP; the first tick is blocked.
        foreach (rows[i]) begin
            regWrite(tmw_pkg::CTRL_OFS, 32'h0000_0000);
            regWrite(tmw_pkg::CMPA_OFS, {16'h0, rows[i].cmpA});
            regWrite(tmw_pkg::CAP_OFS, {16'h0, rows[i].cap});
            regWrite(tmw_pkg::CTRL_OFS, ctrl(rows[i].mode, 2'h0, 1'b0));
            regWrite(tmw_pkg::CNT_OFS, {16'h0, rows[i].cnt});
            regWrite(tmw_pkg::FLAG_OFS, 32'h0000_000F);
            tick(2);
            regRead(tmw_pkg::CNT_OFS, rd);
            check("count", rd, 32'h0000_0000);
            regRead(tmw_pkg::FLAG_OFS, rd);
            check("flags", rd, rows[i].flags);
        end
        check("wave", {31'h0, waveOutA}, 32'h0000_0000);
        // Toggle at compare value zero flips the pin on every tick.
        regWrite(tmw_pkg::CTRL_OFS, ctrl(tmw_pkg::MODE_CTC_CMPA, 2'h1, 1'b1));
        regWrite(tmw_pkg::CMPA_OFS, 32'h0000_0000);
        riseStart = riseCount;
        tick(4);
        @(posedge sys_clk);
        #1 check("rises", {24'h0, riseCount - riseStart}, 32'h0000_0002);
        check("pin", {31'h0, pinLevel}, 32'h0000_0000);
        regWrite(tmw_pkg::CTRL_OFS, ctrl(tmw_pkg::MODE_CTC_CMPA, 2'h1, 1'b0));
        #1 check("oe", {31'h0, waveOutAOe_n}, 32'h0000_0001);
        // Fast PWM at fixed eight-bit TOP, non-inverting then inverting.
        regWrite(tmw_pkg::CTRL_OFS, 32'h0000_0000);
        regWrite(tmw_pkg::CMPA_OFS, 32'h0000_0002);
        regWrite(tmw_pkg::CTRL_OFS, ctrl(tmw_pkg::MODE_FAST8, 2'h2, 1'b1));
        regWrite(tmw_pkg::CNT_OFS, 32'h0000_00FE);
        tick(2);
        check("wave", {31'h0, waveOutA}, 32'h0000_0001);
        tick(3);
        check("wave", {31'h0, waveOutA}, 32'h0000_0000);
        regWrite(tmw_pkg::CTRL_OFS, ctrl(tmw_pkg::MODE_FAST8, 2'h3, 1'b1));
        tick(253);
        check("wave", {31'h0, waveOutA}, 32'h0000_0000);
        tick(3);
        check("wave", {31'h0, waveOutA}, 32'h0000_0001);
        regWrite(tmw_pkg::CMPA_OFS, 32'h0000_1234);
        regRead(tmw_pkg::CMPA_OFS, rd);
        check("compare", rd, 32'h0000_0034);
        regWrite(tmw_pkg::CMPB_OFS, 32'h0000_1234);
        regRead(tmw_pkg::CMPB_OFS, rd);
        check("compareB", rd, 32'h0000_0034);
        // A count write hides a match at the very next tick only.
        regWrite(tmw_pkg::CTRL_OFS, 32'h0000_0000);
        regWrite(tmw_pkg::CMPB_OFS, 32'h0000_0010);
        regWrite(tmw_pkg::FLAG_OFS, 32'h0000_000F);
        regWrite(tmw_pkg::CNT_OFS, 32'h0000_0010);
        tick(1);
        regRead(tmw_pkg::FLAG_OFS, rd);
        check("flags", rd, 32'h0000_0000);
        regWrite(tmw_pkg::CNT_OFS, 32'h0000_000F);
        tick(2);
        regRead(tmw_pkg::FLAG_OFS, rd);
        check("flags", rd, 32'h0000_0004);
        regRead(8'h18, rd);
        check("unmapped", rd, 32'h0000_0000);
        give_verdict();
    end
endmodule

`default_nettype wire
